// File: inc/link_mgmt_pkg.sv
// Constants shared by the link management, pin and wake register group.
package link_mgmt_pkg;

    // Clock and management clock timing.
    localparam int CLK_PERIOD_NS = 25;
    localparam int MDC_MIN_PERIOD_NS = 400;
    localparam int MDC_HALF_CYC = (MDC_MIN_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register indices; the byte address is four times the index.
    localparam logic [9:0] IDX_MEDIA = 10'h137;
    localparam logic [9:0] IDX_PHY_ADDR = 10'h138;
    localparam logic [9:0] IDX_PHY_DATA = 10'h139;
    localparam logic [9:0] IDX_ACCESS = 10'h13B;
    localparam logic [9:0] IDX_GPIO = 10'h13D;
    localparam logic [9:0] IDX_WAKE = 10'h13E;
    localparam logic [9:0] IDX_INT_STAT = 10'h150;
    localparam logic [9:0] IDX_INT_MASK = 10'h151;
    localparam int ADDR_W = 12;

    // Media status fields.
    localparam int MED_TXFC = 7;
    localparam int MED_RXFC = 6;
    localparam int MED_DUPLEX = 4;
    localparam int MED_SPEED = 3;
    localparam int MED_LINK = 2;
    localparam int MED_PSENT = 1;
    localparam int MED_PRCVD = 0;

    // Management access control fields.
    localparam int ACC_GO = 6;
    localparam int ACC_WR = 5;

    // General pin fields.
    localparam int GP_CAP = 4;
    localparam int GP1_VAL = 3;
    localparam int GP1_DIR = 2;
    localparam int GP0_VAL = 1;
    localparam int GP0_DIR = 0;

    // Interrupt status bits.
    localparam int INT_MGMT_DONE = 0;
    localparam int INT_LINK_CHG = 1;
    localparam int INT_WAKE = 2;
    localparam int INT_W = 3;

    // Management frame layout, bit numbers counted from the first preamble bit.
    localparam logic [5:0] FRM_TA_FIRST = 6'h2E;
    localparam logic [5:0] FRM_DATA_FIRST = 6'h30;
    localparam logic [5:0] FRM_LAST = 6'h3F;
    localparam logic [31:0] FRM_PREAMBLE = 32'hFFFFFFFF;
    localparam logic [1:0] FRM_START = 2'h1;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] TA_WRITE = 2'h2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        M_IDLE = 2'b00,
        M_SHIFT = 2'b01,
        M_DONE = 2'b10
    } mgmt_state_t;

endpackage

// File: hdl/link_mgmt_gpio_wake_regs.sv
// Link status, flow control, PHY management, general pins and wake enables behind AXI4-Lite.
//
// Notes on behaviour
// - Negotiated with pause-capable partner: transmit pause enable is read-only, shows result.
// - Otherwise writable; negotiation off in half duplex makes the bit invalid.
// - Receive pause acts only in full duplex; both enables preload from EEPROM.
// - Read-only duplex bit 4, speed bit 3, link bit 2 show link state.
// - Pause-sent bit sets on pause transmit, clears after timer-expiry frame.
// - Pause-received bit stays set while backing off after a received pause.
// - Five-bit writable target PHY address in bits 4-0, upper bits reserved.
// - Sixteen-bit data word: value to write, or value returned by a read.
// - Writing the owner bit starts one transaction; hardware clears it when done.
// - Direction bit 5 set means PHY write, clear means PHY read.
// - Read-only bit 4 of the pin register reports phone-line PHY support.
// - Pin 1 drives its value bit when direction set, else value shows pin.
// - Pin 0 drives its value bit when direction set, else value is read-only.
// - Wake enables reset to zero: link change, pattern packet, frames 4 to 0.
// - Wake reaches host only when remote wakeup armed and an enabled event fired.
// - The auto-negotiation enable comes from PHY control bit 12.
`timescale 1ns/1ps
`default_nettype none

module link_mgmt_gpio_wake_regs #(
    parameter logic PHONE_LINE_CAP = 1'b0,
    parameter int MDC_HALF = link_mgmt_pkg::MDC_HALF_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [link_mgmt_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [link_mgmt_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic irq,
    input wire logic link_up,
    input wire logic full_duplex,
    input wire logic speed_100,
    input wire logic autoneg_on,
    input wire logic partner_autoneg,
    input wire logic partner_pause,
    input wire logic pause_tx_sent,
    input wire logic timer_done_sent,
    input wire logic pause_rx_backoff,
    input wire logic eeprom_loaded,
    input wire logic eeprom_tx_pause,
    input wire logic eeprom_rx_pause,
    output logic tx_pause_enable,
    output logic rx_pause_enable,
    output logic mdc,
    output logic mdio_o,
    output logic mdio_oe_n,
    input wire logic mdio_i,
    output logic gp_pin0_o,
    output logic gp_pin0_oe_n,
    input wire logic gp_pin0_i,
    output logic gp_pin1_o,
    output logic gp_pin1_oe_n,
    input wire logic gp_pin1_i,
    input wire logic remote_wakeup_armed,
    input wire logic pattern_packet_hit,
    input wire logic [4:0] frame_hit,
    output logic wake_signal
);
    import link_mgmt_pkg::*;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic tx_pause_sw;
        logic rx_pause_sw;
        logic tx_pause_eff;
        logic rx_pause_eff;
        logic pause_sent;
        logic pause_rcvd;
        logic [4:0] phy_addr;
        logic [15:0] mgmt_data;
        logic mgmt_go;
        logic mgmt_wr;
        logic [4:0] reg_idx;
        logic [1:0] pin_dir;
        logic [1:0] pin_val;
        logic [1:0] gp_o;
        logic [1:0] gp_oe_n;
        logic [6:0] wake_en;
        logic wake;
        logic [INT_W-1:0] int_stat;
        logic [INT_W-1:0] int_mask;
        logic irq;
        logic link_prev;
        logic link_primed;
        logic [2:0] sync1;
        logic [2:0] sync2;
        mgmt_state_t mst;
        logic [7:0] div;
        logic [5:0] bitn;
        logic [63:0] frame;
        logic mdc;
        logic mdio_o;
        logic mdio_oe_n;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic tx_ro;
    logic tx_invalid;
    logic [6:0] wake_trig;
    logic link_chg;
    logic mdc_tick;

    // Sync slot 0 is the management data line, slots 1 and 2 are the general pins.
    function automatic logic [31:0] read_word(input logic [9:0] idx, input state_t s,
                                              input logic txv);
        logic [31:0] r;
        r = 32'h0;
        if (idx == IDX_MEDIA) begin
            r[MED_TXFC] = txv;
            r[MED_RXFC] = s.rx_pause_sw;
            r[MED_DUPLEX] = full_duplex;
            r[MED_SPEED] = speed_100;
            r[MED_LINK] = link_up;
            r[MED_PSENT] = s.pause_sent;
            r[MED_PRCVD] = s.pause_rcvd;
        end else if (idx == IDX_PHY_ADDR) begin
            r[4:0] = s.phy_addr;
        end else if (idx == IDX_PHY_DATA) begin
            r[15:0] = s.mgmt_data;
        end else if (idx == IDX_ACCESS) begin
            r[ACC_GO] = s.mgmt_go;
            r[ACC_WR] = s.mgmt_wr;
            r[4:0] = s.reg_idx;
        end else if (idx == IDX_GPIO) begin
            r[GP_CAP] = PHONE_LINE_CAP;
            r[GP1_VAL] = s.pin_dir[1] ? s.pin_val[1] : s.sync2[2];
            r[GP1_DIR] = s.pin_dir[1];
            r[GP0_VAL] = s.pin_dir[0] ? s.pin_val[0] : s.sync2[1];
            r[GP0_DIR] = s.pin_dir[0];
        end else if (idx == IDX_WAKE) begin
            r[6:0] = s.wake_en;
        end else if (idx == IDX_INT_STAT) begin
            r[INT_W-1:0] = s.int_stat;
        end else if (idx == IDX_INT_MASK) begin
            r[INT_W-1:0] = s.int_mask;
        end
        return r;
    endfunction

    function automatic logic mapped(input logic [9:0] idx);
        return idx == IDX_MEDIA || idx == IDX_PHY_ADDR || idx == IDX_PHY_DATA ||
               idx == IDX_ACCESS || idx == IDX_GPIO || idx == IDX_WAKE ||
               idx == IDX_INT_STAT || idx == IDX_INT_MASK;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        tx_ro = autoneg_on && partner_autoneg && partner_pause;
        tx_invalid = !autoneg_on && !full_duplex;
        // The first cycle after reset only learns the link level, so no false change is seen.
        link_chg = s_q.link_primed && link_up != s_q.link_prev;
        wake_trig = {link_chg, pattern_packet_hit, frame_hit} & s_q.wake_en;
        mdc_tick = s_q.div == 8'(MDC_HALF - 1);
        s_d.sync1 = {gp_pin1_i, gp_pin0_i, mdio_i};
        s_d.sync2 = s_q.sync1;
        s_d.link_prev = link_up;
        s_d.link_primed = 1'b1;

        // Both defaults reload whenever the EEPROM pass finishes.
        if (eeprom_loaded) begin
            s_d.tx_pause_sw = eeprom_tx_pause;
            s_d.rx_pause_sw = eeprom_rx_pause;
        end

        // A new pause frame in the same cycle as the release frame keeps the flag set.
        s_d.pause_sent = pause_tx_sent || (s_q.pause_sent && !timer_done_sent);
        s_d.pause_rcvd = pause_rx_backoff;

        // AXI write: address and data are taken in either order, then answered together.
        if (awvalid && s_q.awready) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = awaddr;
        end
        if (wvalid && s_q.wready) begin
            s_d.w_got = 1'b1;
            s_d.wdata = wdata;
            s_d.wstrb = wstrb;
        end
        if (s_q.bvalid && bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.aw_got && s_q.w_got) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = mapped(s_q.awaddr[ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
            if (s_q.wstrb[0]) begin
                if (s_q.awaddr[ADDR_W-1:2] == IDX_MEDIA) begin
                    if (!tx_ro) begin
                        s_d.tx_pause_sw = s_q.wdata[MED_TXFC];
                    end
                    s_d.rx_pause_sw = s_q.wdata[MED_RXFC];
                end else if (s_q.awaddr[ADDR_W-1:2] == IDX_PHY_ADDR) begin
                    s_d.phy_addr = s_q.wdata[4:0];
                end else if (s_q.awaddr[ADDR_W-1:2] == IDX_PHY_DATA) begin
                    if (s_q.mst == M_IDLE) begin
                        s_d.mgmt_data[7:0] = s_q.wdata[7:0];
                    end
                end else if (s_q.awaddr[ADDR_W-1:2] == IDX_ACCESS) begin
                    // Control stays frozen while a frame is on the wire.
                    if (s_q.mst == M_IDLE) begin
                        s_d.mgmt_wr = s_q.wdata[ACC_WR];
                        s_d.reg_idx = s_q.wdata[4:0];
                        s_d.mgmt_go = s_q.wdata[ACC_GO];
                    end
                end else if (s_q.awaddr[ADDR_W-1:2] == IDX_GPIO) begin
                    s_d.pin_dir = {s_q.wdata[GP1_DIR], s_q.wdata[GP0_DIR]};
                    if (s_q.wdata[GP1_DIR]) begin
                        s_d.pin_val[1] = s_q.wdata[GP1_VAL];
                    end
                    if (s_q.wdata[GP0_DIR]) begin
                        s_d.pin_val[0] = s_q.wdata[GP0_VAL];
                    end
                end else if (s_q.awaddr[ADDR_W-1:2] == IDX_WAKE) begin
                    s_d.wake_en = s_q.wdata[6:0];
                end else if (s_q.awaddr[ADDR_W-1:2] == IDX_INT_STAT) begin
                    s_d.int_stat = s_q.int_stat & ~s_q.wdata[INT_W-1:0];
                end else if (s_q.awaddr[ADDR_W-1:2] == IDX_INT_MASK) begin
                    s_d.int_mask = s_q.wdata[INT_W-1:0];
                end
            end
            if (s_q.wstrb[1] && s_q.awaddr[ADDR_W-1:2] == IDX_PHY_DATA && s_q.mst == M_IDLE) begin
                s_d.mgmt_data[15:8] = s_q.wdata[15:8];
            end
        end
        s_d.awready = !s_d.aw_got && !s_d.bvalid;
        s_d.wready = !s_d.w_got && !s_d.bvalid;

        // AXI read: one cycle from address to data.
        if (s_q.rvalid && rready) begin
            s_d.rvalid = 1'b0;
        end
        if (arvalid && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = read_word(araddr[ADDR_W-1:2], s_q,
                                  tx_ro ? 1'b1 : (tx_invalid ? 1'b0 : s_q.tx_pause_sw));
            s_d.rresp = mapped(araddr[ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
        end
        s_d.arready = !s_d.rvalid;

        // Management frame engine.
        case (s_q.mst)
            M_IDLE: begin
                s_d.mdc = 1'b0;
                if (s_q.mgmt_go) begin
                    s_d.mst = M_SHIFT;
                    s_d.div = 8'h0;
                    s_d.bitn = 6'h0;
                    s_d.frame = {FRM_PREAMBLE, FRM_START, s_q.mgmt_wr ? OP_WRITE : OP_READ,
                                 s_q.phy_addr, s_q.reg_idx,
                                 s_q.mgmt_wr ? TA_WRITE : 2'h0,
                                 s_q.mgmt_wr ? s_q.mgmt_data : 16'h0};
                end
            end
            M_SHIFT: begin
                s_d.div = s_q.div + 8'h1;
                if (mdc_tick) begin
                    s_d.div = 8'h0;
                    s_d.mdc = !s_q.mdc;
                    if (!s_q.mdc) begin
                        // Rising edge: the PHY's data is stable here.
                        if (!s_q.mgmt_wr && s_q.bitn >= FRM_DATA_FIRST) begin
                            s_d.mgmt_data = {s_q.mgmt_data[14:0], s_q.sync2[0]};
                        end
                    end else if (s_q.bitn == FRM_LAST) begin
                        s_d.mst = M_DONE;
                    end else begin
                        s_d.bitn = s_q.bitn + 6'h1;
                        s_d.frame = {s_q.frame[62:0], 1'b0};
                    end
                end
            end
            M_DONE: begin
                s_d.mst = M_IDLE;
                s_d.mgmt_go = 1'b0;
            end
            default: begin
                s_d.mst = M_IDLE;
            end
        endcase
        s_d.mdio_o = s_d.mst == M_SHIFT ? s_d.frame[63] : 1'b1;
        s_d.mdio_oe_n = s_d.mst != M_SHIFT ||
                        (!s_d.mgmt_wr && s_d.bitn >= FRM_TA_FIRST);

        s_d.gp_oe_n = ~s_d.pin_dir;
        s_d.gp_o = s_d.pin_val;

        s_d.tx_pause_eff = (tx_ro || (!tx_invalid && s_d.tx_pause_sw)) && full_duplex;
        s_d.rx_pause_eff = s_d.rx_pause_sw && full_duplex;

        // Wake holds until the host withdraws remote wakeup.
        s_d.wake = remote_wakeup_armed && (s_q.wake || (|wake_trig));

        // Hardware sets win over a same-cycle software clear.
        s_d.int_stat = s_d.int_stat |
            (INT_W'(s_q.mst == M_DONE) << INT_MGMT_DONE) |
            (INT_W'(link_chg) << INT_LINK_CHG) |
            (INT_W'(|wake_trig) << INT_WAKE);
        s_d.irq = |(s_d.int_stat & s_d.int_mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.mdio_o <= 1'b1;
            s_q.mdio_oe_n <= 1'b1;
            s_q.gp_oe_n <= 2'b11;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign awready = s_q.awready;
    assign wready = s_q.wready;
    assign bvalid = s_q.bvalid;
    assign bresp = s_q.bresp;
    assign arready = s_q.arready;
    assign rvalid = s_q.rvalid;
    assign rdata = s_q.rdata;
    assign rresp = s_q.rresp;
    assign irq = s_q.irq;
    assign tx_pause_enable = s_q.tx_pause_eff;
    assign rx_pause_enable = s_q.rx_pause_eff;
    assign mdc = s_q.mdc;
    assign mdio_o = s_q.mdio_o;
    assign mdio_oe_n = s_q.mdio_oe_n;
    assign gp_pin0_o = s_q.gp_o[0];
    assign gp_pin0_oe_n = s_q.gp_oe_n[0];
    assign gp_pin1_o = s_q.gp_o[1];
    assign gp_pin1_oe_n = s_q.gp_oe_n[1];
    assign wake_signal = s_q.wake;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks. A frame cannot outlast 64 bits of two half periods plus slack.
    logic [15:0] busy_cnt;
    always_ff @(posedge aclk) begin
        if (!aresetn || !s_q.mgmt_go) begin
            busy_cnt <= 16'h0;
        end else begin
            busy_cnt <= busy_cnt + 16'h1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_tx_ro_result: assert property (tx_ro && full_duplex && !eeprom_loaded |=> tx_pause_enable)
        else $error("negotiated pause result not applied");
    a_tx_invalid: assert property (!autoneg_on && !full_duplex |=> !tx_pause_enable)
        else $error("transmit pause active in forced half duplex");
    a_rx_half: assert property (!full_duplex |=> !rx_pause_enable)
        else $error("receive pause active in half duplex");
    a_pause_set: assert property (pause_tx_sent |=> s_q.pause_sent)
        else $error("pause sent flag missed");
    a_pause_clear: assert property (timer_done_sent && !pause_tx_sent |=> !s_q.pause_sent)
        else $error("pause sent flag not released");
    a_go_bounded: assert property (busy_cnt <= 16'(64 * 2 * MDC_HALF + 8))
        else $error("management transaction did not finish");
    a_go_cleared: assert property (s_q.mst == M_DONE |=> !s_q.mgmt_go && s_q.int_stat[INT_MGMT_DONE])
        else $error("owner bit not cleared at completion");
    a_write_drives: assert property (s_q.mst == M_SHIFT && s_q.mgmt_wr |-> !mdio_oe_n)
        else $error("write frame not driven");
    a_read_release: assert property (s_q.mst == M_SHIFT && !s_q.mgmt_wr &&
                                      s_q.bitn >= FRM_TA_FIRST |-> mdio_oe_n)
        else $error("line not released at turnaround");
    a_pin0_drive: assert property (s_q.pin_dir[0] |-> !gp_pin0_oe_n && gp_pin0_o == s_q.pin_val[0])
        else $error("pin 0 not driven from value bit");
    a_pin1_drive: assert property (!s_q.pin_dir[1] |-> gp_pin1_oe_n)
        else $error("pin 1 driven while input");
    a_wake_gate: assert property (!remote_wakeup_armed |=> !wake_signal)
        else $error("wake signalled without remote wakeup");
    a_irq_follow: assert property (##1 irq == |($past(s_d.int_stat) & $past(s_d.int_mask)))
        else $error("interrupt output disagrees with status");

    c_mgmt_read: cover property (s_q.mst == M_DONE && !s_q.mgmt_wr);
    c_mgmt_write: cover property (s_q.mst == M_DONE && s_q.mgmt_wr);
    c_wake: cover property ($rose(wake_signal));
    c_pause_cycle: cover property (s_q.pause_sent ##[1:20] !s_q.pause_sent);

endmodule // link_mgmt_gpio_wake_regs

`default_nettype wire

// File: testbench/phy_mgmt_model.sv
// Behavioural PHY that answers management frames on the shared data line.
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_model (
    input wire logic mdc,
    input wire logic mdio,
    input wire logic slow,
    output logic drv_oe,
    output logic drv_val
);
    logic [63:0] seen;
    logic [15:0] mem [32];
    logic [4:0] ra;
    logic rd;
    int cnt = 0;
    initial {drv_oe, drv_val, rd} = '0;
    // Bits are counted from the first rising edge, since the clock rests low between frames.
    always @(posedge mdc) begin
        seen <= {seen[62:0], mdio};
        cnt <= (cnt == 63) ? 0 : cnt + 1;
        if (cnt == 35) rd <= ({seen[0], mdio} == 2'b10);
        if (cnt == 45) ra <= {seen[3:0], mdio};
        if (cnt == 63 && !rd) mem[ra] <= {seen[14:0], mdio};
    end
    // A slow answer lands late in the half period to probe the sampling margin.
    always @(negedge mdc) begin
        #(slow ? 40 : 1);
        drv_oe = rd && cnt >= 47;
        drv_val = (cnt >= 48) ? mem[ra][63 - cnt] : 1'b0;
    end
endmodule // phy_mgmt_model
`default_nettype wire

// File: testbench/link_mgmt_gpio_wake_regs_tb_top.sv
// Self-checking bench for the link, management, pin and wake register group.
`timescale 1ns/1ps
`default_nettype none
module link_mgmt_gpio_wake_regs_tb_top;
    import link_mgmt_pkg::*;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
    logic rvalid, rready, irq, link_up, full_duplex, speed_100, autoneg_on, partner_autoneg;
    logic partner_pause, pause_tx_sent, timer_done_sent, pause_rx_backoff, eeprom_loaded;
    logic eeprom_tx_pause, eeprom_rx_pause, tx_pause_enable, rx_pause_enable, mdc, mdio_o;
    logic mdio_oe_n, mdio_i, gp_pin0_o, gp_pin0_oe_n, gp_pin0_i, gp_pin1_o, gp_pin1_oe_n;
    logic gp_pin1_i, remote_wakeup_armed, pattern_packet_hit, wake_signal, slow, drv_oe, drv_val;
    logic [11:0] awaddr, araddr;
    logic [2:0] awprot, arprot;
    logic [31:0] wdata, rdata, v, d, seed = 32'hC2ABF35F;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic [4:0] frame_hit;
    bit sw_tx, sw_rx, ps, fly, etx;
    int errors = 0;
    int checks_done = 0;
    // The management line has a pull-up, so a released line reads high.
    assign mdio_i = !mdio_oe_n ? mdio_o : (drv_oe ? drv_val : 1'b1);
    link_mgmt_gpio_wake_regs #(.PHONE_LINE_CAP(1'b1), .MDC_HALF(4)) i_dut (.*);
    phy_mgmt_model u_phy (.mdc(mdc), .mdio(mdio_i), .slow(slow), .drv_oe(drv_oe),
        .drv_val(drv_val));
    ////////////////////////////////////////////////////////////////////////////
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Both ready inputs stay high, which the bus allows and which shortens every transfer.
    task automatic wr(logic [9:0] idx, logic [31:0] x);
        {awaddr, wdata, awvalid, wvalid} <= {idx, 2'b00, x, 2'b11};
        repeat (200) begin
            @(posedge aclk);
            if (awready && awvalid) awvalid <= 1'b0;
            if (wready && wvalid) wvalid <= 1'b0;
            if (bvalid) break;
        end
        resp = bresp;
    endtask
    task automatic rd(logic [9:0] idx);
        {araddr, arvalid} <= {idx, 2'b00, 1'b1};
        repeat (200) begin
            @(posedge aclk);
            if (arready && arvalid) arvalid <= 1'b0;
            if (rvalid) break;
        end
        {resp, d} = {rresp, rdata};
    endtask
    task automatic rchk(string what, logic [9:0] idx, logic [31:0] exp);
        rd(idx);
        check(what, d, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    initial begin
        #(25 * 30000);
        errors++;
        wrap_up();
    end
    initial begin
        {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, awprot, arprot, wdata} = '0;
        {link_up, full_duplex, speed_100, autoneg_on, partner_autoneg, partner_pause} = '0;
        {pause_tx_sent, timer_done_sent, pause_rx_backoff, eeprom_tx_pause, frame_hit} = '0;
        {gp_pin0_i, gp_pin1_i, remote_wakeup_armed, pattern_packet_hit, slow} = '0;
        {bready, rready, wstrb, eeprom_rx_pause, eeprom_loaded} = '1;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        eeprom_loaded <= 1'b0;
        {sw_tx, sw_rx} = 2'b01;
        rchk("wake reset", IDX_WAKE, 0);
        for (int i = 0; i < 8; i++) begin
            v = rnd();
            v[3:1] = ~i[2:0];
            {link_up, full_duplex, speed_100, autoneg_on, partner_autoneg, partner_pause,
                pause_rx_backoff} <= v[6:0];
            fly = (v[3:1] == 3'b111);
            if (v[16]) begin
                pause_tx_sent <= 1'b1;
                ps = 1'b1;
            end else if (v[17]) begin
                timer_done_sent <= 1'b1;
                ps = 1'b0;
            end
            @(posedge aclk);
            {pause_tx_sent, timer_done_sent} <= 2'b00;
            repeat (3) @(posedge aclk);
            etx = fly | (sw_tx & (v[3] | v[5]));
            d = {24'h0, etx, sw_rx, 1'b0, v[5:4], v[6], ps, v[0]};
            rchk("media", IDX_MEDIA, d);
            check("tx enable", tx_pause_enable, v[5] & etx);
            check("rx enable", rx_pause_enable, v[5] & sw_rx);
            wr(IDX_MEDIA, {24'h0, v[15:8]});
            if (!fly) sw_tx = v[15];
            sw_rx = v[14];
        end
        wr(IDX_INT_STAT, 32'h7);
        wr(IDX_INT_MASK, 32'h0);
        v = rnd();
        for (int i = 0; i < 2; i++) begin
            slow <= i[0];
            wr(IDX_PHY_ADDR, {24'h0, 3'h7, v[4:0]});
            rchk("phy addr", IDX_PHY_ADDR, v[4:0]);
            wr(IDX_PHY_DATA, {16'h0, i ? ~v[31:16] : v[31:16]});
            wr(IDX_ACCESS, {25'h0, 1'b1, !i[0], v[9:5]});
            rchk("owner", IDX_ACCESS, {25'h0, 1'b1, !i[0], v[9:5]});
            repeat (400) begin
                rd(IDX_ACCESS);
                if (d[ACC_GO] === 1'b0) break;
            end
            check("done", d, {26'h0, !i[0], v[9:5]});
            check("frame", u_phy.seen, {FRM_PREAMBLE, FRM_START, i ? OP_READ : OP_WRITE,
                v[4:0], v[9:5], 2'b10, v[31:16]});
            rchk("data", IDX_PHY_DATA, v[31:16]);
            check("irq masked", irq, i[0]);
            rchk("status", IDX_INT_STAT, 1);
            wr(IDX_INT_MASK, 1);
            repeat (2) @(posedge aclk);
            check("irq", irq, 1);
            wr(IDX_INT_STAT, 1);
            repeat (2) @(posedge aclk);
            check("irq clear", irq, 0);
        end
        for (int i = 0; i < 2; i++) begin
            wr(IDX_GPIO, i ? 32'h0F : 32'h05);
            repeat (2) @(posedge aclk);
            check("pins out", {gp_pin1_o, gp_pin1_oe_n, gp_pin0_o, gp_pin0_oe_n},
                {i[0], 1'b0, i[0], 1'b0});
            v = rnd();
            {gp_pin1_i, gp_pin0_i} <= v[1:0];
            wr(IDX_GPIO, 32'h0A);
            repeat (4) @(posedge aclk);
            check("pins off", {gp_pin1_oe_n, gp_pin0_oe_n}, 2'b11);
            rchk("pins in", IDX_GPIO, {28'h1, v[1], 1'b0, v[0], 1'b0});
        end
        wr(IDX_WAKE, 32'h24);
        rchk("wake en", IDX_WAKE, 32'h24);
        remote_wakeup_armed <= 1'b1;
        frame_hit <= 5'h02;
        @(posedge aclk);
        frame_hit <= 5'h00;
        repeat (3) @(posedge aclk);
        check("wake off", wake_signal, 0);
        pattern_packet_hit <= 1'b1;
        @(posedge aclk);
        pattern_packet_hit <= 1'b0;
        repeat (3) @(posedge aclk);
        check("wake on", wake_signal, 1);
        remote_wakeup_armed <= 1'b0;
        repeat (3) @(posedge aclk);
        check("wake unarmed", wake_signal, 0);
        rd(10'h100);
        check("unmapped rd", {resp, d}, {RESP_SLVERR, 32'h0});
        wr(10'h100, 1);
        check("unmapped wr", resp, RESP_SLVERR);
        wrap_up();
    end
endmodule // link_mgmt_gpio_wake_regs_tb_top
`default_nettype wire
